// file: apsc_pkg.sv
// Shared constants and types for the synthesizer control block.
// Assumes one 200 MHz clock shared by both ends of the link.
package apsc_pkg;

    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int INT_W   = 10;
    localparam int FRAC_W  = 27;
    localparam int RAT_W   = INT_W + FRAC_W;
    localparam int CAP_W   = 6;
    localparam int LPF_W   = 4;
    localparam int RANGE_W = 2;
    localparam int BLK_N   = 4;
    localparam int WORD_LSB_EXP = 40;

    // Device register addresses on the link
    localparam logic [7:0] REG_MODE   = 8'h00;
    localparam logic [7:0] REG_XCAP   = 8'h01;
    localparam logic [7:0] REG_REFIN  = 8'h02;
    localparam logic [7:0] REG_FILTER = 8'h03;
    localparam logic [7:0] REG_FBINT  = 8'h04;
    localparam logic [7:0] REG_FBFRAC = 8'h05;
    localparam logic [7:0] REG_FREQ   = 8'h06;
    localparam logic [7:0] REG_TRIM   = 8'h07;
    localparam logic [7:0] REG_STATUS = 8'h08;

    // Field positions
    localparam int MODE_CLKGEN = 0;
    localparam int MODE_DCO    = 1;
    localparam int XCAP_OUT    = 8;
    localparam int REF_CMOS    = 0;
    localparam int REF_BIAS    = 1;
    localparam int REF_BUF     = 2;
    localparam int REF_DBL     = 3;
    localparam int REF_SEL     = 4;
    localparam int REF_RANGE   = 8;
    localparam int FLT_CP      = 4;
    localparam int FLT_R3      = 8;
    localparam int FLT_C3      = 12;
    localparam int FLT_BYP     = 16;
    localparam int ST_CALDONE  = 0;
    localparam int ST_CALFAIL  = 1;
    localparam int ST_LOCK     = 2;
    localparam int ST_LOL      = 3;
    localparam int ST_READY    = 4;

    // Values after reset
    localparam logic [INT_W-1:0]  FBINT_RST  = 10'h064;
    localparam logic [FRAC_W-1:0] FBFRAC_RST = 27'h000_0000;
    localparam logic [LPF_W-1:0]  LPF_RST    = 4'h0;
    localparam logic [CAP_W-1:0]  CAP_RST    = 6'h00;

    // Host command port offsets (APB byte addresses)
    localparam logic [7:0] HOST_CMD    = 8'h00;
    localparam logic [7:0] HOST_WDATA  = 8'h04;
    localparam logic [7:0] HOST_RDATA  = 8'h08;
    localparam logic [7:0] HOST_STATUS = 8'h0C;
    localparam int CMD_WRITE = 8;

    // Block release spacing during startup
    localparam int CLK_NS    = 5;
    localparam int STAGE_NS  = 100;
    localparam int STAGE_CYC = (STAGE_NS + CLK_NS - 1) / CLK_NS;

    typedef enum logic [1:0] {
        PH_HOLD,
        PH_BIAS,
        PH_STAGE,
        PH_RUN
    } apsc_phase_type;

endpackage

// file: apsc_link_if.sv
// Register link between the host controller and the device.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface apsc_link_if;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        ack;
    logic [31:0] rdata;

    modport device (
        input  req,
        input  we,
        input  addr,
        input  wdata,
        output ack,
        output rdata
    );

    modport host (
        output req,
        output we,
        output addr,
        output wdata,
        input  ack,
        input  rdata
    );
endinterface

// file: apsc_sdm.sv
// Second-order MASH modulator for the feedback divider.
// Assumes a ratio in units of 2^-27, stepped once per clock.
`timescale 1ns/100ps
module apsc_sdm
    import apsc_pkg::*;
(
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [RAT_W-1:0] ratio,
    output logic      [INT_W+1:0] step_ratio
);

    typedef struct packed {
        logic [FRAC_W-1:0] acc1;
        logic [FRAC_W-1:0] acc2;
        logic              c2_prev;
        logic [INT_W+1:0]  out;
    } apsc_sdm_type;

    apsc_sdm_type s_reg;
    apsc_sdm_type s_next;

    always_comb begin
        logic [FRAC_W:0] sum1;
        logic [FRAC_W:0] sum2;
        sum1 = {1'b0, s_reg.acc1} + {1'b0, ratio[FRAC_W-1:0]};
        sum2 = {1'b0, s_reg.acc2} + {1'b0, sum1[FRAC_W-1:0]};
        s_next = s_reg;
        s_next.acc1 = sum1[FRAC_W-1:0];
        s_next.acc2 = sum2[FRAC_W-1:0];
        s_next.c2_prev = sum2[FRAC_W];
        // Ratio dithers among int-1 .. int+2
        s_next.out = {2'b00, ratio[RAT_W-1:FRAC_W]} + {{INT_W+1{1'b0}}, sum1[FRAC_W]}
                   + {{INT_W+1{1'b0}}, sum2[FRAC_W]} - {{INT_W+1{1'b0}}, s_reg.c2_prev};
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign step_ratio = s_reg.out;

endmodule

// file: apsc_device.sv
// Device end: configuration registers, startup sequencing, lock
// status and the fractional feedback ratio with offset scaling.
// Assumes analog status inputs are asynchronous to clock.
`timescale 1ns/100ps

// Operation
// - DCO word scaled by ratio, applied
// - Crystal trim offset added to word
// - Offset word LSB is two^-40
// - Hold blocks, release in sequence
// - Calibration done and fail readable
// - Separate crystal pin capacitance fields
// - One bit selects CMOS or differential
// - Host sets bias for AC coupling
// - Input buffer disabled after reset
// - Doubler enable doubles the reference
// - Select bit picks crystal or reference
// - Host bypasses third pole only integer
// - Four loop filter value fields
// - Sigma-delta drives multi-modulus divider
// - Ratio is integer plus 27-bit fraction
// - Host avoids fractions near 0,1,half
// - Lock status readable and on pin
// - Lock fall sets sticky loss bit
// - Host sets lock detector range
// - Synth modes use crystal or input
// - Clock generator uses differential input
// - Input buffer configured per mode
module apsc_device
    import apsc_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               reset_n,
    apsc_link_if.device             link,
    input  wire logic               regulator_ok,
    input  wire logic               bias_cal_done_in,
    input  wire logic               bias_cal_fail_in,
    input  wire logic               pll_lock_in,
    output logic [BLK_N-1:0]        block_release,
    output logic [CAP_W-1:0]        xin_cap,
    output logic [CAP_W-1:0]        xout_cap,
    output logic                    ref_buffer_enable,
    output logic                    ref_buffer_cmos,
    output logic                    input_bias_enable,
    output logic                    doubler_enable,
    output logic                    ref_select_input,
    output logic [LPF_W-1:0]        filter_series_resistor,
    output logic [LPF_W-1:0]        filter_parallel_capacitor,
    output logic [LPF_W-1:0]        filter_pole3_resistor,
    output logic [LPF_W-1:0]        filter_pole3_capacitor,
    output logic                    third_pole_bypass,
    output logic [RANGE_W-1:0]      lock_range,
    output logic [INT_W+1:0]        mmd_step_ratio,
    output logic                    lock_gpio
);

    typedef struct packed {
        logic [1:0]         reg_s;
        logic [1:0]         done_s;
        logic [1:0]         fail_s;
        logic [1:0]         lock_s;
        logic               lock;
        logic               lol;
        logic               cal_done;
        logic               cal_fail;
        apsc_phase_type     phase;
        logic [7:0]         step_cnt;
        logic [BLK_N-1:0]   rel;
        logic               clkgen;
        logic               dco;
        logic [CAP_W-1:0]   xin;
        logic [CAP_W-1:0]   xout;
        logic [7:0]         refin;
        logic [RANGE_W-1:0] range;
        logic [16:0]        filter;
        logic [INT_W-1:0]   fb_int;
        logic [FRAC_W-1:0]  fb_frac;
        logic [31:0]        freq;
        logic [31:0]        trim;
        logic [RAT_W-1:0]   ratio;
        logic               buf_cmos;
        logic               src_input;
        logic               ack;
        logic [31:0]        rdata;
        logic [INT_W+1:0]   multi_modulus_divider;
    } apsc_dev_type;

    apsc_dev_type d_reg;
    apsc_dev_type d_next;
    logic [INT_W+1:0] sdm_out;

    // Offset in 2^-27 units: N * word * 2^-40
    function automatic logic [RAT_W-1:0] apsc_scale(
        input logic [RAT_W-1:0] n,
        input logic [31:0]      word
    );
        logic signed [RAT_W+32:0] prod;
        prod = $signed({1'b0, n}) * $signed(word);
        return RAT_W'(prod >>> WORD_LSB_EXP);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic       wr;
        logic       lock_fall;
        logic [31:0] word;
        d_next = d_reg;
        wr = link.req && link.we;
        word = 32'h0000_0000;
        lock_fall = d_reg.lock && !d_reg.lock_s[1];
        d_next.reg_s  = {d_reg.reg_s[0], regulator_ok};
        d_next.done_s = {d_reg.done_s[0], bias_cal_done_in};
        d_next.fail_s = {d_reg.fail_s[0], bias_cal_fail_in};
        d_next.lock_s = {d_reg.lock_s[0], pll_lock_in};
        d_next.lock = d_reg.lock_s[1];

        case (d_reg.phase)
            PH_HOLD: begin
                d_next.rel = '0;
                if (d_reg.reg_s[1]) begin
                    d_next.phase = PH_BIAS;
                    d_next.rel = {{BLK_N-1{1'b0}}, 1'b1};
                end
            end
            PH_BIAS: begin
                if (d_reg.done_s[1] || d_reg.fail_s[1]) begin
                    d_next.cal_done = d_reg.done_s[1];
                    d_next.cal_fail = d_reg.fail_s[1];
                    d_next.phase = PH_STAGE;
                    d_next.step_cnt = '0;
                end
            end
            PH_STAGE: begin
                if (d_reg.step_cnt == 8'(STAGE_CYC - 1)) begin
                    d_next.step_cnt = '0;
                    d_next.rel = {d_reg.rel[BLK_N-2:0], 1'b1};
                    if (d_reg.rel[BLK_N-2]) begin
                        d_next.phase = PH_RUN;
                    end
                end else begin
                    d_next.step_cnt = d_reg.step_cnt + 8'd1;
                end
            end
            PH_RUN: begin
                d_next.rel = '1;
            end
            default: begin
                d_next.phase = PH_HOLD;
            end
        endcase

        d_next.ack = link.req;
        if (link.req) begin
            case (link.addr)
                REG_MODE: word = {30'h0000_0000, d_reg.dco, d_reg.clkgen};
                REG_XCAP: word = {18'h0_0000, d_reg.xout, 2'b00, d_reg.xin};
                REG_REFIN: word = {22'h00_0000, d_reg.range, d_reg.refin};
                REG_FILTER: word = {15'h0000, d_reg.filter};
                REG_FBINT: word = {22'h00_0000, d_reg.fb_int};
                REG_FBFRAC: word = {5'h00, d_reg.fb_frac};
                REG_FREQ: word = d_reg.freq;
                REG_TRIM: word = d_reg.trim;
                REG_STATUS: word = {27'h000_0000, d_reg.phase == PH_RUN, d_reg.lol,
                                    d_reg.lock, d_reg.cal_fail, d_reg.cal_done};
                default: word = 32'h0000_0000;
            endcase
        end
        d_next.rdata = word;

        if (wr) begin
            case (link.addr)
                REG_MODE: begin
                    d_next.clkgen = link.wdata[MODE_CLKGEN];
                    d_next.dco = link.wdata[MODE_DCO];
                end
                REG_XCAP: begin
                    d_next.xin = link.wdata[CAP_W-1:0];
                    d_next.xout = link.wdata[XCAP_OUT +: CAP_W];
                end
                REG_REFIN: begin
                    d_next.refin = link.wdata[7:0];
                    d_next.range = link.wdata[REF_RANGE +: RANGE_W];
                end
                REG_FILTER: d_next.filter = link.wdata[16:0];
                REG_FBINT: d_next.fb_int = link.wdata[INT_W-1:0];
                REG_FBFRAC: d_next.fb_frac = link.wdata[FRAC_W-1:0];
                REG_FREQ: d_next.freq = link.wdata;
                REG_TRIM: d_next.trim = link.wdata;
                default: ;
            endcase
        end

        // sticky loss of lock; write one clears, set wins
        d_next.lol = (d_reg.lol && !(wr && link.addr == REG_STATUS && link.wdata[ST_LOL]))
                   || lock_fall;

        // scale word by ratio; trim adds; 2^-40 LSB
        if (d_reg.clkgen) begin
            d_next.ratio = {d_reg.fb_int, d_reg.fb_frac};
        end else begin
            d_next.ratio = {d_reg.fb_int, d_reg.fb_frac}
                + apsc_scale({d_reg.fb_int, d_reg.fb_frac},
                             (d_reg.dco ? d_reg.freq : 32'h0000_0000) + d_reg.trim);
        end

        // synth modes follow select bit; source select
        d_next.src_input = d_reg.clkgen || d_reg.refin[REF_SEL];
        d_next.buf_cmos = !d_reg.clkgen && d_reg.refin[REF_CMOS];
        d_next.multi_modulus_divider = sdm_out;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            d_reg <= '0;
            d_reg.phase <= PH_HOLD;
            d_reg.fb_int <= FBINT_RST;
            d_reg.fb_frac <= FBFRAC_RST;
            d_reg.xin <= CAP_RST;
            d_reg.xout <= CAP_RST;
            d_reg.ratio <= {FBINT_RST, FBFRAC_RST};
        end else begin
            d_reg <= d_next;
        end
    end

    apsc_sdm u_sdm (
        .clock      (clock),
        .reset_n    (reset_n),
        .ratio      (d_reg.ratio),
        .step_ratio (sdm_out)
    );

    ////////////////////////////////////////////////////////////////////////
    assign link.ack = d_reg.ack;
    assign link.rdata = d_reg.rdata;
    assign block_release = d_reg.rel;
    assign xin_cap = d_reg.xin;
    assign xout_cap = d_reg.xout;
    assign ref_buffer_enable = d_reg.refin[REF_BUF];
    assign ref_buffer_cmos = d_reg.buf_cmos;
    assign input_bias_enable = d_reg.refin[REF_BIAS];
    assign doubler_enable = d_reg.refin[REF_DBL];
    assign ref_select_input = d_reg.src_input;
    assign filter_series_resistor = d_reg.filter[LPF_W-1:0];
    assign filter_parallel_capacitor = d_reg.filter[FLT_CP +: LPF_W];
    assign filter_pole3_resistor = d_reg.filter[FLT_R3 +: LPF_W];
    assign filter_pole3_capacitor = d_reg.filter[FLT_C3 +: LPF_W];
    assign third_pole_bypass = d_reg.filter[FLT_BYP];
    assign lock_range = d_reg.range;
    assign mmd_step_ratio = d_reg.multi_modulus_divider;
    assign lock_gpio = d_reg.lock;

endmodule

// file: apsc_host.sv
// Host end: APB slave command port that runs one link transfer per
// command. Software keeps the host-side obligations on values written.
`timescale 1ns/100ps
module apsc_host
    import apsc_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    apsc_link_if.host        link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr
);

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        req;
        logic        we;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        busy;
    } apsc_host_type;

    apsc_host_type h_reg;
    apsc_host_type h_next;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic acc;
        logic done;
        logic map;
        h_next = h_reg;
        acc = psel && penable && !h_reg.pready;
        done = psel && penable && h_reg.pready;
        map = (paddr == HOST_CMD) || (paddr == HOST_WDATA)
           || (paddr == HOST_RDATA) || (paddr == HOST_STATUS);
        h_next.pready = acc;
        h_next.pslverr = acc && !map;
        h_next.prdata = 32'h0000_0000;
        if (acc && !pwrite) begin
            case (paddr)
                HOST_CMD: h_next.prdata = {23'h00_0000, h_reg.we, h_reg.addr};
                HOST_WDATA: h_next.prdata = h_reg.wdata;
                HOST_RDATA: h_next.prdata = h_reg.rdata;
                HOST_STATUS: h_next.prdata = {31'h0000_0000, h_reg.busy};
                default: h_next.prdata = 32'h0000_0000;
            endcase
        end
        h_next.req = 1'b0;
        if (done && pwrite) begin
            if (paddr == HOST_WDATA) begin
                h_next.wdata = pwdata;
            end
            if (paddr == HOST_CMD && !h_reg.busy) begin
                h_next.addr = pwdata[7:0];
                h_next.we = pwdata[CMD_WRITE];
                h_next.req = 1'b1;
                h_next.busy = 1'b1;
            end
        end
        if (link.ack && h_reg.busy) begin
            h_next.busy = 1'b0;
            h_next.rdata = link.rdata;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            h_reg <= '0;
        end else begin
            h_reg <= h_next;
        end
    end

    assign pready = h_reg.pready;
    assign prdata = h_reg.prdata;
    assign pslverr = h_reg.pslverr;
    assign link.req = h_reg.req;
    assign link.we = h_reg.we;
    assign link.addr = h_reg.addr;
    assign link.wdata = h_reg.wdata;

endmodule

// file: apsc_link_props.sv
// Checker for the register link: handshake timing, status bits and
// reset values as seen on the wire between host and device.
// Assumes one clock; the link signals arrive as plain inputs.
`timescale 1ns/100ps
module apsc_link_props
    import apsc_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        req,
    input wire logic        we,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        ack,
    input wire logic [31:0] rdata
);
    logic       rd_reg;
    logic [7:0] addr_reg;
    logic [1:0] cal_reg;
    logic       lol_reg;
    logic       fbint_wr_reg;
    logic       stat_rd;
    logic       fbint_rd;

    assign stat_rd  = ack && rd_reg && addr_reg == REG_STATUS;
    assign fbint_rd = ack && rd_reg && addr_reg == REG_FBINT;

    // Remembers the last request and what status reads have shown
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_reg       <= 1'b0;
            addr_reg     <= 8'h00;
            cal_reg      <= 2'h0;
            lol_reg      <= 1'b0;
            fbint_wr_reg <= 1'b0;
        end else begin
            if (req) begin
                rd_reg   <= !we;
                addr_reg <= addr;
            end
            if (stat_rd && rdata[1:0] != 2'h0) cal_reg <= rdata[1:0];
            if (stat_rd && rdata[ST_LOL]) lol_reg <= 1'b1;
            else if (req && we && addr == REG_STATUS && wdata[ST_LOL]) lol_reg <= 1'b0;
            if (req && we && addr == REG_FBINT) fbint_wr_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////
    property p_ack_follows_req;
        req |=> ack;
    endproperty
    a_ack_follows_req: assert property (p_ack_follows_req)
        else $error("no answer one cycle after a request");

    property p_ack_has_cause;
        ack |-> $past(req);
    endproperty
    a_ack_has_cause: assert property (p_ack_has_cause)
        else $error("answer without a request");

    property p_req_single;
        req |=> !req [*2];
    endproperty
    a_req_single: assert property (p_req_single)
        else $error("host issued requests too close together");

    property p_rdata_quiet;
        !ack |-> rdata == 32'h0000_0000;
    endproperty
    a_rdata_quiet: assert property (p_rdata_quiet)
        else $error("read data not zero outside an answer");

    property p_cal_latched;
        stat_rd && cal_reg != 2'h0 |-> rdata[1:0] == cal_reg;
    endproperty
    a_cal_latched: assert property (p_cal_latched)
        else $error("calibration status changed after latching");

    property p_ready_needs_cal;
        stat_rd && rdata[ST_READY] |-> rdata[ST_CALDONE] || rdata[ST_CALFAIL];
    endproperty
    a_ready_needs_cal: assert property (p_ready_needs_cal)
        else $error("startup done before calibration finished");

    property p_lol_sticky;
        stat_rd && lol_reg |-> rdata[ST_LOL];
    endproperty
    a_lol_sticky: assert property (p_lol_sticky)
        else $error("loss of lock bit dropped without a clear");

    property p_fbint_reset;
        fbint_rd && !fbint_wr_reg |-> rdata[INT_W-1:0] == FBINT_RST;
    endproperty
    a_fbint_reset: assert property (p_fbint_reset)
        else $error("feedback integer not at its reset value");

    c_write: cover property (req && we);
    c_lol_seen: cover property (stat_rd && rdata[ST_LOL]);
    c_fbint_rd: cover property (fbint_rd);
endmodule

// file: apll_synth_dco_control_tb_top.sv
// Testbench: host and device joined by the link, host driven over APB.
// Assumes 200 MHz clock; device analog status inputs driven directly.
`timescale 1ns/100ps
module apll_synth_dco_control_tb_top
    import apsc_pkg::*;
;
    typedef struct {logic [7:0] a; logic [31:0] d, o, r;} apsc_row_type;
    logic        clock, reset_n, regulator_ok, bias_cal_done_in, bias_cal_fail_in;
    logic        pll_lock_in, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  block_release, filter_series_resistor, filter_parallel_capacitor;
    logic [3:0]  filter_pole3_resistor, filter_pole3_capacitor;
    logic [5:0]  xin_cap, xout_cap;
    logic        ref_buffer_enable, ref_buffer_cmos, input_bias_enable, doubler_enable;
    logic        ref_select_input, third_pole_bypass, lock_gpio;
    logic [1:0]  lock_range;
    logic [11:0] mmd_step_ratio;
    int          n_errors = 0;
    int          checked = 0;
    int          n;
    apsc_row_type rows[6] = '{
        '{REG_XCAP, 32'h0000_2A15, 32'h0000_0A95, 32'h0000_2A15},
        '{REG_XCAP, 32'hFFFF_FFFF, 32'h0000_0FFF, 32'h0000_3F3F},
        '{REG_REFIN, 32'h0000_0315, 32'h0000_0075, 32'h0000_0315},
        '{REG_REFIN, 32'h0000_020A, 32'h0000_004A, 32'h0000_020A},
        '{REG_FILTER, 32'h0001_4321, 32'h0001_4321, 32'h0001_4321},
        '{REG_FILTER, 32'h0000_8765, 32'h0000_8765, 32'h0000_8765}};

    apsc_link_if link ();
    apsc_host apsc_host_inst (.clock, .reset_n, .link(link.host), .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr);
    apsc_device apsc_device_inst (.clock, .reset_n, .link(link.device), .regulator_ok,
        .bias_cal_done_in, .bias_cal_fail_in, .pll_lock_in, .block_release, .xin_cap,
        .xout_cap, .ref_buffer_enable, .ref_buffer_cmos, .input_bias_enable,
        .doubler_enable, .ref_select_input, .filter_series_resistor,
        .filter_parallel_capacitor, .filter_pole3_resistor, .filter_pole3_capacitor,
        .third_pole_bypass, .lock_range, .mmd_step_ratio, .lock_gpio);
    apsc_link_props apsc_link_props_inst (.clock, .reset_n, .req(link.req), .we(link.we),
        .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One APB transfer; pready sampled at rising edges
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int k;
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        last_err = pslverr;
        if (k >= 50) n_errors++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // One device register access through the host command port
    task automatic dev(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int k;
        if (w) apb(1'b1, HOST_WDATA, d, r);
        apb(1'b1, HOST_CMD, 32'(a) | (32'(w) << CMD_WRITE), r);
        k = 0;
        do begin
            apb(1'b0, HOST_STATUS, 32'h0, r);
            k++;
        end while (r[0] !== 1'b0 && k < 20);
        if (r[0] !== 1'b0) n_errors++;
        apb(1'b0, HOST_RDATA, 32'h0, r);
    endtask

    // Sums the divider steps over 400 cycles, against an expected sum
    task automatic ratio(input int exp, input int tol);
        int s;
        s = 0;
        repeat (8) @(posedge clock);
        repeat (400) begin
            @(negedge clock);
            s += int'(mmd_step_ratio);
        end
        chk(32'(s >= exp - tol && s <= exp + tol), 32'h1);
    endtask

    function automatic logic [31:0] observe(input logic [7:0] a);
        case (a)
            REG_XCAP: return {20'h0, xout_cap, xin_cap};
            REG_REFIN: return {25'h0, lock_range, ref_select_input, doubler_enable,
                               ref_buffer_enable, input_bias_enable, ref_buffer_cmos};
            default: return {15'h0, third_pole_bypass, filter_pole3_capacitor,
                             filter_pole3_resistor, filter_parallel_capacitor,
                             filter_series_resistor};
        endcase
    endfunction

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    initial begin
        #100_000;
        n_errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset_n, regulator_ok, bias_cal_done_in, bias_cal_fail_in, pll_lock_in} = 5'h0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        chk(32'(ref_buffer_enable), 32'h0);
        dev(1'b0, REG_FBINT, 32'h0, q);
        chk(q, 32'(FBINT_RST));
        dev(1'b0, 8'h3F, 32'h0, q);
        chk(q, 32'h0);
        apb(1'b0, 8'h20, 32'h0, q);
        chk(32'(last_err), 32'h1);
        chk(32'(block_release), 32'h0);
        regulator_ok <= 1'b1;
        n = 0;
        while (block_release !== 4'h1 && n < 10) begin
            @(negedge clock);
            n++;
        end
        repeat (40) @(posedge clock);
        chk(32'(block_release), 32'h1);
        bias_cal_fail_in <= 1'b1;
        n = 0;
        while (block_release !== 4'h3 && n < 40) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        while (block_release === 4'h3 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk(32'(n), 32'(STAGE_CYC));
        chk(32'(block_release), 32'h7);
        repeat (25) @(posedge clock);
        chk(32'(block_release), 32'hF);
        dev(1'b0, REG_STATUS, 32'h0, q);
        chk(q, 32'h0000_0012);
        foreach (rows[i]) begin
            dev(1'b1, rows[i].a, rows[i].d, q);
            chk(observe(rows[i].a), rows[i].o);
            dev(1'b0, rows[i].a, 32'h0, q);
            chk(q, rows[i].r);
        end
        pll_lock_in <= 1'b1;
        repeat (6) @(posedge clock);
        chk(32'(lock_gpio), 32'h1);
        dev(1'b0, REG_STATUS, 32'h0, q);
        chk(q, 32'h0000_0016);
        pll_lock_in <= 1'b0;
        repeat (6) @(posedge clock);
        chk(32'(lock_gpio), 32'h0);
        dev(1'b1, REG_STATUS, 32'h0, q);
        dev(1'b0, REG_STATUS, 32'h0, q);
        chk(q, 32'h0000_001A);
        dev(1'b1, REG_STATUS, 32'h0000_0008, q);
        dev(1'b0, REG_STATUS, 32'h0, q);
        chk(q, 32'h0000_0012);
        // Ratio 256 makes a word of 2^30 worth a quarter step
        dev(1'b1, REG_FBINT, 32'h0000_0100, q);
        dev(1'b1, REG_FREQ, 32'h4000_0000, q);
        ratio(102400, 0);
        dev(1'b1, REG_MODE, 32'h0000_0002, q);
        ratio(102500, 4);
        dev(1'b1, REG_TRIM, 32'hC000_0000, q);
        ratio(102400, 4);
        dev(1'b1, REG_MODE, 32'h0000_0000, q);
        ratio(102300, 4);
        dev(1'b1, REG_FBFRAC, 32'h0100_0000, q);
        dev(1'b1, REG_MODE, 32'h0000_0001, q);
        ratio(102450, 4);
        chk(32'({ref_select_input, ref_buffer_cmos}), 32'h2);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        chk(32'({ref_buffer_enable, xin_cap}), 32'h0);
        stop_test();
    end
endmodule
